// [hdl/abec_ctrl.sv]
// abec_ctrl: block-by-block sequencing of automatic operation
// assumes a program source offering blocks and an executor reporting completion
//
// Functional notes
// - single step halts after current block
// - idle single step does nothing, start runs one
// - inside fixed cycle stop at permitted point
// - block interlock holds next block, no suspension
// - cutting interlock holds non-positioning motion blocks
// - interlocks cover internally generated blocks too
// - interlocks not inhibiting from power-on
// - dry run rapid select: max cut feed
// - dry run manual feed, override if valid
// - rapid dry run only when enabled
// - no dry run manually; tapping keeps it
// - exact stop check after cutting blocks
// - exact stop input equals programmed exact stop
// - reset one keeps modal, indexes memory
// - reset one clears alarms, stops, flags reset
`timescale 1ns/1ns
`default_nettype none
module abec_ctrl
    import abec_pkg::*;
#(
    parameter int unsigned CS_MIN = CS_MIN_CYCLES
) (
    // clock, reset, scan enable
    input  wire logic              i_clk_sys,
    input  wire logic              i_rstn,
    input  wire logic              i_ce,
    // operation mode and operator controls
    input  wire logic              i_auto_mode,
    input  wire logic              i_manual_mode,
    input  wire logic              i_cycle_start_cmd,
    input  wire logic              i_feed_hold_n,
    input  wire logic              i_single_step_sel,
    input  wire logic              i_block_start_inhibit_n,
    input  wire logic              i_cut_block_start_inhibit_n,
    input  wire logic              i_exact_stop_check,
    input  wire logic              i_reset_in_one,
    // feed selection
    input  wire logic              i_dry_feed_sel,
    input  wire logic              i_rapid_sel,
    input  wire logic              i_manual_override_valid,
    input  wire logic [JOG_W-1:0]  i_manual_feed_setting,
    input  wire logic              i_dry_rapid_en,
    input  wire logic [FEED_W-1:0] i_max_cut_feed,
    input  wire logic [FEED_W-1:0] i_rapid_feed,
    // program source
    input  wire logic              i_blk_valid,
    input  wire abec_blk_t         i_blk,
    output logic                   o_blk_take,
    // executor
    output logic                   o_blk_start,
    output abec_blk_t              o_blk_cur,
    output abec_feed_t             o_feed,
    input  wire logic              i_blk_done,
    output logic                   o_inpos_req,
    input  wire logic              i_inpos_ok,
    input  wire logic              i_alarm,
    // status
    output logic                   o_auto_run,
    output logic                   o_block_busy,
    output logic                   o_single_stop,
    output logic                   o_feed_hold,
    output logic                   o_in_reset,
    output logic                   o_axis_stop,
    output logic                   o_mem_index,
    output logic                   o_alarm_clear,
    output logic                   o_mcode_end_off,
    output logic                   o_modal_keep
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT,
        ST_EXEC,
        ST_INPOS,
        ST_SSTOP,
        ST_HOLD
    } abec_state_t;

    abec_state_t state_q;
    abec_state_t state_d;

    // scan-sampled levels
    abec_ilk_t   ilk_q;
    logic        sbk_q;
    logic        erd_q;
    logic        hold_n_q;
    logic        auto_q;
    logic        rst1_q;
    logic        blk_valid_q;
    abec_blk_t   blk_q;
    abec_blk_t   cur_q;
    logic        start_q;
    logic        busy_q;
    logic        rst_pulse_q;
    logic        cs_rel;
    logic        may_start;
    logic        take;
    logic        stop_here;
    logic        need_inpos;

    function automatic logic is_motion_cut(input abec_kind_t k);
        return (k == ABEC_KIND_CUT) || (k == ABEC_KIND_TAP);
    endfunction : is_motion_cut

    abec_start_edge #(
        .MIN_CYCLES (CS_MIN)
    ) u_start (
        .i_clk_sys         (i_clk_sys),
        .i_rstn            (i_rstn),
        .i_ce              (i_ce),
        .i_cycle_start_cmd (i_cycle_start_cmd),
        .o_release         (cs_rel)
    );

    abec_feed_sel u_feed (
        .i_clk_sys               (i_clk_sys),
        .i_rstn                  (i_rstn),
        .i_ce                    (i_ce),
        .i_load                  (take),
        .i_blk                   (blk_q),
        .i_dry_feed_sel          (i_dry_feed_sel),
        .i_rapid_sel             (i_rapid_sel),
        .i_manual_override_valid (i_manual_override_valid),
        .i_manual_feed_setting   (i_manual_feed_setting),
        .i_dry_rapid_en          (i_dry_rapid_en),
        .i_manual_mode           (i_manual_mode),
        .i_max_cut_feed          (i_max_cut_feed),
        .i_rapid_feed            (i_rapid_feed),
        .o_feed                  (o_feed)
    );

    // one sample per scan of the interlock, single step, exact stop, hold, auto, reset one and block inputs
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            ilk_q       <= '{INHIBIT_N_RST, INHIBIT_N_RST};
            sbk_q       <= 1'b0;
            erd_q       <= 1'b0;
            hold_n_q    <= 1'b1;
            auto_q      <= 1'b0;
            rst1_q      <= 1'b0;
            blk_valid_q <= 1'b0;
            blk_q       <= '0;
        end else if (i_ce) begin
            ilk_q       <= '{i_block_start_inhibit_n, i_cut_block_start_inhibit_n};
            sbk_q       <= i_single_step_sel;
            erd_q       <= i_exact_stop_check;
            hold_n_q    <= i_feed_hold_n;
            auto_q      <= i_auto_mode;
            rst1_q      <= i_reset_in_one;
            blk_valid_q <= i_blk_valid && !take;
            blk_q       <= i_blk;
        end
    end

    // interlocks gate every block, internal ones included
    always_comb begin
        may_start = ilk_q.block_start_inhibit_n;
        if (is_motion_cut(blk_q.kind) && !ilk_q.cut_block_start_inhibit_n) begin
            may_start = 1'b0;
        end
    end

    assign take       = (state_q == ST_WAIT) && blk_valid_q && may_start && !rst1_q && i_ce;
    assign need_inpos = is_motion_cut(cur_q.kind) && (erd_q || cur_q.exact_stop);
    assign stop_here  = sbk_q && (!cur_q.in_cycle || cur_q.stop_ok);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (cs_rel && auto_q && hold_n_q && !i_alarm) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!hold_n_q) begin
                    state_d = ST_HOLD;
                end else if (take) begin
                    state_d = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (i_blk_done) begin
                    if (need_inpos) begin
                        state_d = ST_INPOS;
                    end else if (stop_here) begin
                        state_d = ST_SSTOP;
                    end else begin
                        state_d = ST_WAIT;
                    end
                end else if (!hold_n_q) begin
                    state_d = ST_HOLD;
                end
            end
            ST_INPOS: begin
                if (i_inpos_ok) begin
                    state_d = stop_here ? ST_SSTOP : ST_WAIT;
                end
            end
            ST_SSTOP: begin
                if (cs_rel && hold_n_q && !i_alarm) begin
                    state_d = ST_WAIT;
                end
            end
            ST_HOLD: begin
                if (cs_rel && hold_n_q && !i_alarm) begin
                    state_d = busy_q ? ST_EXEC : ST_WAIT;
                end
            end
        endcase
        if (rst1_q || !auto_q || i_alarm) begin
            state_d = ST_IDLE;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            state_q <= ST_IDLE;
        end else if (i_ce) begin
            state_q <= state_d;
        end
    end

    // current block and busy flag
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            cur_q   <= '0;
            busy_q  <= 1'b0;
            start_q <= 1'b0;
        end else if (i_ce) begin
            start_q <= take;
            if (take) begin
                cur_q  <= blk_q;
                busy_q <= 1'b1;
            end else if (i_blk_done || rst1_q) begin
                busy_q <= 1'b0;
            end
        end
    end

    // reset one: one-scan pulse for memory index and alarm clear
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            rst_pulse_q <= 1'b0;
        end else if (i_ce) begin
            rst_pulse_q <= i_reset_in_one && !rst1_q;
        end
    end

    assign o_blk_take      = take;
    assign o_blk_start     = start_q && i_ce;
    assign o_blk_cur       = cur_q;
    assign o_inpos_req     = (state_q == ST_INPOS);
    assign o_auto_run      = (state_q == ST_WAIT) || (state_q == ST_EXEC) || (state_q == ST_INPOS);
    assign o_block_busy    = busy_q;
    assign o_single_stop   = (state_q == ST_SSTOP);
    assign o_feed_hold     = (state_q == ST_HOLD);
    assign o_in_reset      = rst1_q;
    assign o_axis_stop     = rst1_q || (state_q == ST_HOLD) || (state_q == ST_INPOS);
    assign o_mem_index     = rst_pulse_q && i_ce;
    assign o_alarm_clear   = rst_pulse_q && i_ce;
    assign o_mcode_end_off = rst1_q;
    assign o_modal_keep    = 1'b1;
endmodule : abec_ctrl
`default_nettype wire

// [hdl/abec_feed_sel.sv]
// abec_feed_sel: dry run feedrate substitution for the block being started
// assumes kind and levels are stable while o_feed is loaded
`timescale 1ns/1ns
`default_nettype none
module abec_feed_sel
    import abec_pkg::*;
(
    // clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_rstn,
    input  wire logic              i_ce,
    // load strobe and block
    input  wire logic              i_load,
    input  wire abec_blk_t         i_blk,
    // operator selections
    input  wire logic              i_dry_feed_sel,
    input  wire logic              i_rapid_sel,
    input  wire logic              i_manual_override_valid,
    input  wire logic [JOG_W-1:0]  i_manual_feed_setting,
    input  wire logic              i_dry_rapid_en,
    input  wire logic              i_manual_mode,
    input  wire logic [FEED_W-1:0] i_max_cut_feed,
    input  wire logic [FEED_W-1:0] i_rapid_feed,
    // decision
    output abec_feed_t             o_feed
);
    abec_feed_t feed_d;
    abec_feed_t feed_q;
    logic       dry;
    logic       cutting;
    logic [FEED_W-1:0] manual_rate;

    assign manual_rate = FEED_W'(i_manual_feed_setting);

    always_comb begin
        dry     = i_dry_feed_sel && !i_manual_mode;
        cutting = (i_blk.kind == ABEC_KIND_CUT) || (i_blk.kind == ABEC_KIND_TAP);
        feed_d  = '{rate: i_blk.feed, cut_ovr_en: 1'b1, rapid_ovr_en: 1'b0};
        if (cutting) begin
            if (dry && i_rapid_sel) begin
                feed_d = '{rate: i_max_cut_feed, cut_ovr_en: 1'b0, rapid_ovr_en: 1'b0};
            end else if (dry) begin
                feed_d = '{rate: manual_rate, cut_ovr_en: i_manual_override_valid, rapid_ovr_en: 1'b0};
            end
        end else if (i_blk.kind == ABEC_KIND_POSITION) begin
            if (dry && i_dry_rapid_en && !i_rapid_sel) begin
                feed_d = '{rate: manual_rate, cut_ovr_en: 1'b0, rapid_ovr_en: 1'b0};
            end else begin
                feed_d = '{rate: i_rapid_feed, cut_ovr_en: 1'b0, rapid_ovr_en: 1'b1};
            end
        end else begin
            feed_d = '{rate: '0, cut_ovr_en: 1'b0, rapid_ovr_en: 1'b0};
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            feed_q <= '0;
        end else if (i_ce && i_load) begin
            feed_q <= feed_d;
        end
    end

    assign o_feed = feed_q;
endmodule : abec_feed_sel
`default_nettype wire

// [hdl/abec_pkg.sv]
// abec_pkg: constants and carrier types for the automatic block execution control
// assumes a single 25 MHz scan clock; no register bus, all controls are plain ports
package abec_pkg;

    // timing
    localparam int unsigned CLK_PERIOD_NS   = 40;
    localparam int unsigned CS_MIN_HOLD_MS  = 100;
    localparam int unsigned CS_MIN_CYCLES   = (CS_MIN_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CS_CNT_W        = 22;

    // widths
    localparam int unsigned FEED_W          = 16;
    localparam int unsigned JOG_W           = 5;

    // power-on levels of the active-low interlocks (not inhibiting)
    localparam logic        INHIBIT_N_RST   = 1'b1;

    typedef enum logic [1:0] {
        ABEC_KIND_NOMOVE,
        ABEC_KIND_POSITION,
        ABEC_KIND_CUT,
        ABEC_KIND_TAP
    } abec_kind_t;

    // block offered by the program source
    typedef struct packed {
        abec_kind_t          kind;
        logic                in_cycle;
        logic                stop_ok;
        logic                exact_stop;
        logic                internal;
        logic [FEED_W-1:0]   feed;
    } abec_blk_t;

    // feed decision handed to the interpolator
    typedef struct packed {
        logic [FEED_W-1:0]   rate;
        logic                cut_ovr_en;
        logic                rapid_ovr_en;
    } abec_feed_t;

    // interlock samples
    typedef struct packed {
        logic                block_start_inhibit_n;
        logic                cut_block_start_inhibit_n;
    } abec_ilk_t;

endpackage : abec_pkg

// [hdl/abec_start_edge.sv]
// abec_start_edge: cycle start release detector with minimum hold time
// assumes the push button level is synchronous to i_clk_sys
`timescale 1ns/1ns
`default_nettype none
module abec_start_edge
    import abec_pkg::*;
#(
    parameter int unsigned MIN_CYCLES = CS_MIN_CYCLES
) (
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rstn,
    input  wire logic i_ce,
    // button
    input  wire logic i_cycle_start_cmd,
    // release pulse
    output logic      o_release
);
    localparam logic [CS_CNT_W-1:0] MIN_C = CS_CNT_W'(MIN_CYCLES);

    logic                cs_q;
    logic [CS_CNT_W-1:0] hold_q;
    logic                rel_q;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            cs_q <= 1'b0;
        end else if (i_ce) begin
            cs_q <= i_cycle_start_cmd;
        end
    end

    // saturating on-time count
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            hold_q <= '0;
        end else if (i_ce) begin
            if (!i_cycle_start_cmd) begin
                hold_q <= '0;
            end else if (hold_q < MIN_C) begin
                hold_q <= hold_q + 1'b1;
            end
        end
    end

    // act on the on-to-off transition only after the minimum hold
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            rel_q <= 1'b0;
        end else if (i_ce) begin
            rel_q <= cs_q && !i_cycle_start_cmd && (hold_q >= MIN_C);
        end
    end

    assign o_release = rel_q && i_ce;
endmodule : abec_start_edge
`default_nettype wire

// [verif/abec_ctrl_asserts.sv]
// abec_ctrl_asserts: port properties of the block sequencer
// assumes i_ce high, so every edge is one scan
`timescale 1ns/1ns
`default_nettype none
module abec_ctrl_asserts
    import abec_pkg::*;
#(
    parameter int unsigned CS_MIN = CS_MIN_CYCLES
) (
    // clock, reset, controls
    input wire logic      i_clk_sys,
    input wire logic      i_rstn,
    input wire logic      i_cycle_start_cmd,
    input wire logic      i_block_start_inhibit_n,
    input wire logic      i_cut_block_start_inhibit_n,
    input wire logic      i_reset_in_one,
    input wire abec_blk_t i_blk,
    // watched outputs
    input wire logic      o_blk_take,
    input wire logic      o_inpos_req,
    input wire logic      o_auto_run,
    input wire logic      o_single_stop,
    input wire logic      o_in_reset,
    input wire logic      o_axis_stop,
    input wire logic      o_mem_index,
    input wire logic      o_alarm_clear,
    input wire logic      o_mcode_end_off
);
    default clocking @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);

    property p_bsl; o_blk_take |-> $past(i_block_start_inhibit_n); endproperty
    a_bsl: assert property (p_bsl) else $error("take under block interlock");
    property p_csl; o_blk_take && ($past(i_blk.kind) inside {ABEC_KIND_CUT, ABEC_KIND_TAP}) |->
        $past(i_cut_block_start_inhibit_n); endproperty
    a_csl: assert property (p_csl) else $error("cut take under cut interlock");
    property p_sstop; o_single_stop |-> !o_blk_take; endproperty
    a_sstop: assert property (p_sstop) else $error("take while single stopped");
    property p_idle; !o_auto_run |-> !o_blk_take; endproperty
    a_idle: assert property (p_idle) else $error("take while not running");
    property p_inpos; o_inpos_req |-> !o_blk_take; endproperty
    a_inpos: assert property (p_inpos) else $error("take before in-position");
    property p_start; $rose(o_auto_run) |-> !$past(i_cycle_start_cmd) && !$past(i_reset_in_one); endproperty
    a_start: assert property (p_start) else $error("run without start release");
    property p_rst_out; $rose(i_reset_in_one) |=> o_in_reset && o_axis_stop && o_mcode_end_off; endproperty
    a_rst_out: assert property (p_rst_out) else $error("reset one outputs missing");
    property p_rst_pulse; $rose(i_reset_in_one) |=> (o_mem_index && o_alarm_clear) ##1 !o_mem_index; endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("index pulse wrong");
    property p_rst_idle; o_in_reset |=> !o_auto_run; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("running in reset");

    c_take: cover property (o_blk_take);
    c_sstop: cover property ($rose(o_single_stop));
    c_inpos: cover property (o_inpos_req ##1 !o_inpos_req);
    c_reset: cover property ($rose(o_in_reset));
endmodule : abec_ctrl_asserts

bind abec_ctrl abec_ctrl_asserts #(.CS_MIN(CS_MIN)) u_asserts (.*);
`default_nettype wire

// [verif/abec_ctrl_test.sv]
// abec_ctrl_test: self-checking bench for the block sequencer
// assumes the executor model answers blocks; the bench plays the sequence logic
`timescale 1ns/1ns
`default_nettype none
module abec_ctrl_test;
    import abec_pkg::*;
    localparam int unsigned CS = 4;
    typedef struct packed {
        abec_kind_t  kind;
        logic [3:0]  sel;
        logic [15:0] rate;
        logic [1:0]  ovm;
        logic [1:0]  ov;
    } abec_row_t;
    // dry, rapid, override valid, rapid dry enable -> rate and override bits
    abec_row_t rows [8] = '{
        '{ABEC_KIND_CUT, 4'h0, 16'h0123, 2'h0, 2'h0}, '{ABEC_KIND_CUT, 4'hc, 16'h0456, 2'h3, 2'h0},
        '{ABEC_KIND_CUT, 4'ha, 16'h000a, 2'h2, 2'h2}, '{ABEC_KIND_CUT, 4'h8, 16'h000a, 2'h2, 2'h0},
        '{ABEC_KIND_POSITION, 4'h8, 16'h0789, 2'h0, 2'h0}, '{ABEC_KIND_POSITION, 4'hd, 16'h0789, 2'h0, 2'h0},
        '{ABEC_KIND_POSITION, 4'h9, 16'h000a, 2'h0, 2'h0}, '{ABEC_KIND_TAP, 4'ha, 16'h000a, 2'h2, 2'h2}};
    logic clk = 1'h0, rstn = 1'h0, cs = 1'h0, hold_n = 1'h1, ss = 1'h0, ecs = 1'h0, r1 = 1'h0;
    logic bsl_n = 1'h1, csl_n = 1'h1;
    logic man = 1'h0, ce = 1'h1;
    logic dry = 1'h0, rt = 1'h0, ovv = 1'h0, dre = 1'h0, valid = 1'h0, slow = 1'h0, seen = 1'h0;
    logic [4:0] jog = 5'h0a;
    logic [15:0] maxf = 16'h0456, rapf = 16'h0789;
    abec_blk_t blk = '0;
    abec_feed_t feed;
    logic take, bstart, done, ireq, iok, run, busy, sstop, in_rst, mk;
    int error_cnt = 0, checks = 0, takes = 0;

    abec_ctrl #(.CS_MIN(CS)) dut_u (
        .i_clk_sys(clk), .i_rstn(rstn), .i_ce(ce), .i_auto_mode(1'h1), .i_manual_mode(man),
        .i_cycle_start_cmd(cs), .i_feed_hold_n(hold_n), .i_single_step_sel(ss),
        .i_block_start_inhibit_n(bsl_n), .i_cut_block_start_inhibit_n(csl_n),
        .i_exact_stop_check(ecs), .i_reset_in_one(r1), .i_dry_feed_sel(dry), .i_rapid_sel(rt),
        .i_manual_override_valid(ovv), .i_manual_feed_setting(jog), .i_dry_rapid_en(dre),
        .i_max_cut_feed(maxf), .i_rapid_feed(rapf), .i_blk_valid(valid), .i_blk(blk),
        .o_blk_take(take), .o_blk_start(bstart), .o_blk_cur(), .o_feed(feed), .i_blk_done(done),
        .o_inpos_req(ireq), .i_inpos_ok(iok), .i_alarm(1'h0), .o_auto_run(run), .o_block_busy(busy),
        .o_single_stop(sstop), .o_feed_hold(), .o_in_reset(in_rst), .o_axis_stop(), .o_mem_index(),
        .o_alarm_clear(), .o_mcode_end_off(), .o_modal_keep(mk));
    abec_exec_model exec_u (.i_clk_sys(clk), .i_rstn(rstn), .i_slow(slow), .i_blk_start(bstart),
        .i_inpos_req(ireq), .o_blk_done(done), .o_inpos_ok(iok));

    initial begin
        forever #20 clk = ~clk;
    end
    always @(negedge clk) begin
        if (take === 1'h1) takes++;
        if (ireq === 1'h1) seen = 1'h1;
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic press(input int len);
        @(posedge clk) cs <= 1'h1;
        repeat (len) @(posedge clk);
        cs <= 1'h0;
        // returns while a block waiting at start is still being taken
        repeat (3) @(negedge clk);
    endtask : press
    task automatic offer(input abec_kind_t k, input logic c, input logic s, input logic e, input logic n);
        @(posedge clk) blk <= '{k, c, s, e, n, 16'h0123};
        valid <= 1'h1;
    endtask : offer
    task automatic finish();
        int n = 0;
        while (take !== 1'h1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        cmp(take, 1'h1);
        @(posedge clk) valid <= 1'h0;
        @(negedge clk);
        while (busy !== 1'h0 && n < 90) begin
            @(negedge clk);
            n++;
        end
        repeat (2) @(negedge clk);
    endtask : finish
    task automatic held();
        int n0 = takes;
        repeat (8) @(negedge clk);
        cmp(takes - n0, 0);
    endtask : held
    task automatic tally_and_finish();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'h1;
        @(negedge clk);
        cmp({run, in_rst, mk}, 3'h1);
        @(posedge clk) hold_n <= 1'h0;
        press(CS + 2);
        cmp(run, 1'h0);
        @(posedge clk) hold_n <= 1'h1;
        press(CS - 1);
        cmp(run, 1'h0);
        press(CS);
        cmp(run, 1'h1);
        foreach (rows[i]) begin
            @(posedge clk) {dry, rt, ovv, dre} <= rows[i].sel;
            offer(rows[i].kind, 1'h0, 1'h0, 1'h0, 1'h0);
            finish();
            cmp(feed.rate, rows[i].rate);
            cmp({feed.cut_ovr_en, feed.rapid_ovr_en} & rows[i].ovm, rows[i].ov);
        end
        @(posedge clk) {man, dry} <= 2'h3;
        offer(ABEC_KIND_CUT, 1'h0, 1'h0, 1'h0, 1'h0);
        finish();
        cmp(feed.rate, 16'h0123);
        @(posedge clk) {man, dry, rt, ovv, dre} <= 5'h0;
        ce <= 1'h0;
        offer(ABEC_KIND_NOMOVE, 1'h0, 1'h0, 1'h0, 1'h0);
        held();
        @(posedge clk) ce <= 1'h1;
        finish();
        @(posedge clk) bsl_n <= 1'h0;
        offer(ABEC_KIND_CUT, 1'h0, 1'h0, 1'h0, 1'h1);
        held();
        cmp(run, 1'h1);
        @(posedge clk) bsl_n <= 1'h1;
        finish();
        @(posedge clk) csl_n <= 1'h0;
        offer(ABEC_KIND_POSITION, 1'h0, 1'h0, 1'h0, 1'h0);
        finish();
        offer(ABEC_KIND_TAP, 1'h1, 1'h0, 1'h0, 1'h1);
        held();
        cmp(run, 1'h1);
        @(posedge clk) csl_n <= 1'h1;
        finish();
        @(posedge clk) ss <= 1'h1;
        offer(ABEC_KIND_CUT, 1'h1, 1'h0, 1'h0, 1'h0);
        finish();
        cmp(sstop, 1'h0);
        offer(ABEC_KIND_CUT, 1'h1, 1'h1, 1'h0, 1'h0);
        finish();
        cmp(sstop, 1'h1);
        offer(ABEC_KIND_NOMOVE, 1'h0, 1'h0, 1'h0, 1'h0);
        held();
        @(posedge clk) r1 <= 1'h1;
        repeat (3) @(negedge clk);
        cmp({in_rst, sstop, run}, 3'h4);
        @(posedge clk) r1 <= 1'h0;
        held();
        press(CS + 2);
        finish();
        cmp(sstop, 1'h1);
        @(posedge clk) ss <= 1'h0;
        press(CS + 2);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) ecs <= (i == 0);
            slow <= (i == 1);
            seen = 1'h0;
            offer(ABEC_KIND_CUT, 1'h0, 1'h0, i == 1, 1'h0);
            finish();
            repeat (8) @(negedge clk);
            cmp(seen, i < 2);
        end
        tally_and_finish();
    end
endmodule : abec_ctrl_test
`default_nettype wire

// [verif/abec_exec_model.sv]
// abec_exec_model: executor stand-in, ends blocks and reports in-position
// assumes start pulse and in-position request come on i_clk_sys
`timescale 1ns/1ns
`default_nettype none
module abec_exec_model #(
    parameter int unsigned INPOS_DLY = 5
) (
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rstn,
    // sequencer side
    input  wire logic i_slow,
    input  wire logic i_blk_start,
    input  wire logic i_inpos_req,
    output logic      o_blk_done,
    output logic      o_inpos_ok
);
    logic [3:0] run_q;
    logic [3:0] settle_q;

    // motion time, short or long
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            run_q <= 4'h0;
        end else if (i_blk_start) begin
            run_q <= i_slow ? 4'hc : 4'h2;
        end else if (run_q != 4'h0) begin
            run_q <= run_q - 4'h1;
        end
    end
    assign o_blk_done = (run_q == 4'h1);

    // settling only while asked
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn || !i_inpos_req) begin
            settle_q <= 4'h0;
        end else if (settle_q != 4'(INPOS_DLY)) begin
            settle_q <= settle_q + 4'h1;
        end
    end
    assign o_inpos_ok = (settle_q == 4'(INPOS_DLY));
endmodule : abec_exec_model
`default_nettype wire
